// file: logic/pmc_pkg.sv
// Shared constants and types of the power-mode and configuration block.
package pmc_pkg;

  // ************************************************************
  // Register map: indices, byte address is four times the index
  // ************************************************************
  localparam logic [5:0] IDX_VERSION  = 6'h00;
  localparam logic [5:0] IDX_AMP1_CFG = 6'h01;
  localparam logic [5:0] IDX_AMP2_CFG = 6'h02;
  localparam logic [5:0] IDX_MOD_CFG  = 6'h03;
  localparam logic [5:0] IDX_PWR_CFG  = 6'h04;
  localparam logic [5:0] IDX_STATUS   = 6'h05;

  // Value is arbitrary, it only marks this build of the block.
  localparam logic [7:0] VERSION_VALUE = 8'h5A;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [7:0] AMP1_CFG_RST = 8'h00;
  localparam logic [7:0] AMP2_CFG_RST = 8'h00;
  localparam logic [7:0] MOD_CFG_RST  = 8'h00;
  localparam logic [7:0] PWR_CFG_RST  = 8'h30;
  localparam int         PWR_PD_CH1   = 5;
  localparam int         PWR_PD_CH2   = 4;
  localparam int         ST_LOST      = 4;
  localparam int         ST_ACTIVE_LO = 2;
  localparam int         ST_MODE_LO   = 0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CORE_PERIOD_NS  = 8;
  localparam int LOSS_TIME_NS    = 40000;
  localparam int LOSS_CYCLES     = LOSS_TIME_NS / CORE_PERIOD_NS;
  localparam int MCLK_RATE_KHZ   = 2048;
  localparam int STREAM_RATE_KHZ = 512;
  localparam int STREAM_DIV      = MCLK_RATE_KHZ / STREAM_RATE_KHZ;
  localparam logic [2:0] STREAM_DIV_LAST = 3'(STREAM_DIV - 1);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_REG_PD,
    MODE_CLK_PD
  } pmc_mode_t;

  typedef struct packed {
    logic [7:0] amp1;
    logic [7:0] amp2;
    logic [7:0] modulator;
    logic [7:0] power;
  } pmc_cfg_t;

endpackage : pmc_pkg

// file: logic/pmc_clk_loss.sv
// Detector for a stopped master clock, running on the core clock.
module pmc_clk_loss #(
  parameter int LIMIT = pmc_pkg::LOSS_CYCLES
) (
  input  wire logic clk,        // Core clock.
  input  wire logic rstn,       // Asynchronous reset, active low.
  input  wire logic mclk_tog,   // Toggles on every rising master clock edge.
  output logic      lost        // High while the master clock is stopped.
);

  logic        tog_s1_reg;
  logic        tog_s2_reg;
  logic        tog_s3_reg;
  logic [15:0] idle_cnt_reg;
  logic [15:0] idle_cnt_next;
  logic        lost_reg;
  logic        lost_next;
  wire  logic  mclk_seen = tog_s2_reg ^ tog_s3_reg;
  wire  logic  at_limit  = (idle_cnt_reg == 16'(LIMIT - 1));

  // ************************************************************
  // Crossing and idle counting
  // ************************************************************
  // The detector starts in the lost state: no edge has arrived yet.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tog_s1_reg   <= 1'b0;
      tog_s2_reg   <= 1'b0;
      tog_s3_reg   <= 1'b0;
      idle_cnt_reg <= 16'h0000;
      lost_reg     <= 1'b1;
    end else begin
      tog_s1_reg   <= mclk_tog;
      tog_s2_reg   <= tog_s1_reg;
      tog_s3_reg   <= tog_s2_reg;
      idle_cnt_reg <= idle_cnt_next;
      lost_reg     <= lost_next;
    end
  end

  assign idle_cnt_next = mclk_seen ? 16'h0000 :
                         (at_limit ? idle_cnt_reg : idle_cnt_reg + 16'h0001);
  assign lost_next     = mclk_seen ? 1'b0 : (lost_reg | at_limit);
  assign lost          = lost_reg;

  a_loss_after_idle: assert property (@(posedge clk) disable iff (!rstn)
    $rose(lost_reg) |-> $past(idle_cnt_reg) == 16'(LIMIT - 1))
    else $error("Clock loss declared before the idle time ran out.");

  a_edge_clears_loss: assert property (@(posedge clk) disable iff (!rstn)
    mclk_seen |=> !lost_reg && idle_cnt_reg == 16'h0000)
    else $error("A master clock edge did not clear the loss state.");

endmodule // pmc_clk_loss

// file: logic/pmc_top.sv
// Power-mode control, configuration registers and modulator stream output.
//
// Chosen here: strobed register access and the register offsets.
module pmc_top #(
  parameter int LOSS_LIMIT = pmc_pkg::LOSS_CYCLES
) (
  input  wire logic        CORE_CLK,     // Core clock, 125 MHz.
  input  wire logic        RSTN,         // Asynchronous reset, active low.
  input  wire logic        MCLK,         // Master clock from the filter.
  input  wire logic [7:0]  REG_ADDR,     // Register byte address.
  input  wire logic [31:0] REG_WDATA,    // Register write data.
  input  wire logic        REG_WR,       // Write strobe.
  input  wire logic        REG_RD,       // Read strobe.
  output logic      [31:0] REG_RDATA,    // Read data, one cycle after the strobe.
  input  wire logic [1:0]  MOD_IN,       // Quantiser decisions per channel.
  output logic      [1:0]  MOD_OUT,      // One-bit modulator streams.
  output logic      [1:0]  MOD_OE,       // Stream output enables.
  output logic      [1:0]  AMP_HIZ,      // Analog pins floated per channel.
  output logic             MICRO_POWER   // Both channels off.
);

  // ************************************************************
  // Declarations
  // ************************************************************
  pmc_pkg::pmc_cfg_t  cfg_reg;
  pmc_pkg::pmc_cfg_t  cfg_next;
  pmc_pkg::pmc_mode_t mode_reg;
  pmc_pkg::pmc_mode_t mode_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic               clk_lost;
  logic [1:0]         pd_bits;
  logic [1:0]         ch_active;
  logic [7:0]         status_byte;

  logic               mclk_tog_reg;
  logic [1:0]         act_s1_reg;
  logic [1:0]         act_s2_reg;
  logic [1:0]         in_s1_reg;
  logic [1:0]         in_s2_reg;
  logic [2:0]         div_cnt_reg;
  logic [2:0]         div_cnt_next;
  logic [1:0]         stream_reg;
  logic [1:0]         stream_next;
  logic [1:0]         oe_link_reg;

  // ************************************************************
  // Register decode
  // ************************************************************
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
  endfunction

  wire logic wr_amp1 = REG_WR && hit(REG_ADDR, pmc_pkg::IDX_AMP1_CFG);
  wire logic wr_amp2 = REG_WR && hit(REG_ADDR, pmc_pkg::IDX_AMP2_CFG);
  wire logic wr_mod  = REG_WR && hit(REG_ADDR, pmc_pkg::IDX_MOD_CFG);
  wire logic wr_pwr  = REG_WR && hit(REG_ADDR, pmc_pkg::IDX_PWR_CFG);

  // Writes are honoured in every mode; the core clock never stops, so the
  // register file stays reachable even while both channels sleep.
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_amp1) begin
      cfg_next.amp1 = REG_WDATA[7:0];
    end
    if (wr_amp2) begin
      cfg_next.amp2 = REG_WDATA[7:0];
    end
    if (wr_mod) begin
      cfg_next.modulator = REG_WDATA[7:0];
    end
    if (wr_pwr) begin
      cfg_next.power = REG_WDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_reg.amp1      <= pmc_pkg::AMP1_CFG_RST;
      cfg_reg.amp2      <= pmc_pkg::AMP2_CFG_RST;
      cfg_reg.modulator <= pmc_pkg::MOD_CFG_RST;
      cfg_reg.power     <= pmc_pkg::PWR_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  assign status_byte = {3'h0, clk_lost, ch_active, mode_reg};

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (REG_RD) begin
      if (hit(REG_ADDR, pmc_pkg::IDX_VERSION)) begin
        rdata_next = {24'h00_0000, pmc_pkg::VERSION_VALUE};
      end else if (hit(REG_ADDR, pmc_pkg::IDX_AMP1_CFG)) begin
        rdata_next = {24'h00_0000, cfg_reg.amp1};
      end else if (hit(REG_ADDR, pmc_pkg::IDX_AMP2_CFG)) begin
        rdata_next = {24'h00_0000, cfg_reg.amp2};
      end else if (hit(REG_ADDR, pmc_pkg::IDX_MOD_CFG)) begin
        rdata_next = {24'h00_0000, cfg_reg.modulator};
      end else if (hit(REG_ADDR, pmc_pkg::IDX_PWR_CFG)) begin
        rdata_next = {24'h00_0000, cfg_reg.power};
      end else if (hit(REG_ADDR, pmc_pkg::IDX_STATUS)) begin
        rdata_next = {24'h00_0000, status_byte};
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

  // ************************************************************
  // Clock loss detection
  // ************************************************************
  // A toggle flip-flop carries master clock activity into the core domain.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      mclk_tog_reg <= 1'b0;
    end else begin
      mclk_tog_reg <= ~mclk_tog_reg;
    end
  end

  pmc_clk_loss #(
    .LIMIT    (LOSS_LIMIT)
  ) u_clk_loss (
    .clk      (CORE_CLK),
    .rstn     (RSTN),
    .mclk_tog (mclk_tog_reg),
    .lost     (clk_lost)
  );

  // ************************************************************
  // Power mode
  // ************************************************************
  // A set bit asks for power down of that channel.
  assign pd_bits[0] = cfg_reg.power[pmc_pkg::PWR_PD_CH1];
  assign pd_bits[1] = cfg_reg.power[pmc_pkg::PWR_PD_CH2];

  // Each channel only looks at its own bit and at clock loss.
  assign ch_active = ~pd_bits & {2{~clk_lost}};

  // Clock loss overrides whatever the configuration asks for.
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pmc_pkg::MODE_NORMAL: begin
        if (clk_lost) begin
          mode_next = pmc_pkg::MODE_CLK_PD;
        end else if (pd_bits == 2'h3) begin
          mode_next = pmc_pkg::MODE_REG_PD;
        end
      end
      pmc_pkg::MODE_REG_PD: begin
        if (clk_lost) begin
          mode_next = pmc_pkg::MODE_CLK_PD;
        end else if (pd_bits != 2'h3) begin
          mode_next = pmc_pkg::MODE_NORMAL;
        end
      end
      pmc_pkg::MODE_CLK_PD: begin
        if (!clk_lost) begin
          mode_next = (pd_bits == 2'h3) ? pmc_pkg::MODE_REG_PD : pmc_pkg::MODE_NORMAL;
        end
      end
      default: begin
        mode_next = pmc_pkg::MODE_CLK_PD;
      end
    endcase
  end

  // Reset lands in the deepest state, since no master clock is running yet.
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_reg <= pmc_pkg::MODE_CLK_PD;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign AMP_HIZ     = ~ch_active;
  assign MICRO_POWER = (ch_active == 2'h0);

  // ************************************************************
  // Modulator stream, master clock domain
  // ************************************************************
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      act_s1_reg <= 2'h0;
      act_s2_reg <= 2'h0;
      in_s1_reg  <= 2'h0;
      in_s2_reg  <= 2'h0;
    end else begin
      act_s1_reg <= ch_active;
      act_s2_reg <= act_s1_reg;
      in_s1_reg  <= MOD_IN;
      in_s2_reg  <= in_s1_reg;
    end
  end

  wire logic stream_tick = (div_cnt_reg == pmc_pkg::STREAM_DIV_LAST);

  assign div_cnt_next = stream_tick ? 3'h0 : div_cnt_reg + 3'h1;
  // Stopped channels hold a zero so a wake-up starts from a clean level.
  assign stream_next  = stream_tick ? (in_s2_reg & act_s2_reg) : stream_reg;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      div_cnt_reg <= 3'h0;
      stream_reg  <= 2'h0;
      oe_link_reg <= 2'h0;
    end else begin
      div_cnt_reg <= div_cnt_next;
      stream_reg  <= stream_next;
      oe_link_reg <= act_s2_reg;
    end
  end

  // The link-side enable freezes when the master clock stops, so the core
  // side enable also gates the pin and floats it as soon as loss is seen.
  assign MOD_OUT = stream_reg;
  assign MOD_OE  = oe_link_reg & ch_active;

  // ************************************************************
  // Checks
  // ************************************************************
  a_pd_floats_pin: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    pd_bits[0] |-> !MOD_OE[0] && AMP_HIZ[0])
    else $error("Channel one drives while its power-down bit is set.");

  a_loss_floats_all: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    clk_lost |-> MOD_OE == 2'h0 && AMP_HIZ == 2'h3 && MICRO_POWER)
    else $error("Outputs not floated during clock loss.");

  a_loss_mode_entry: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    clk_lost |=> mode_reg == pmc_pkg::MODE_CLK_PD)
    else $error("Mode did not follow clock loss within one cycle.");

  a_loss_keeps_cfg: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    clk_lost && !REG_WR |=> $stable(cfg_reg))
    else $error("Configuration changed during clock loss without a write.");

  a_resume_cfg_mode: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $fell(clk_lost) && $stable(pd_bits) |-> mode_reg == pmc_pkg::MODE_CLK_PD ##1
      mode_reg == ((pd_bits == 2'h3) ? pmc_pkg::MODE_REG_PD : pmc_pkg::MODE_NORMAL))
    else $error("Mode after clock return ignores retained configuration.");

  a_chan_indep: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $changed(pd_bits[0]) && $stable(pd_bits[1]) && $stable(clk_lost) |-> $stable(ch_active[1]))
    else $error("Channel two reacted to channel one power down.");

  a_pwr_write_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    REG_WR && hit(REG_ADDR, pmc_pkg::IDX_PWR_CFG) ##1 REG_RD && hit(REG_ADDR, pmc_pkg::IDX_PWR_CFG)
      |=> REG_RDATA == {24'h00_0000, $past(REG_WDATA[7:0], 2)})
    else $error("Power configuration read back differs from the write.");

  a_mod_shared_read: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    REG_RD && hit(REG_ADDR, pmc_pkg::IDX_MOD_CFG) |=> REG_RDATA[7:0] == $past(cfg_reg.modulator)
      && REG_RDATA[31:8] == 24'h00_0000)
    else $error("Modulator configuration read returned wrong data.");

  // The mode register trails the power bits by one cycle, so the check starts from the bits.
  a_normal_runs: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !clk_lost && pd_bits != 2'h3 |-> !MICRO_POWER ##1 mode_reg == pmc_pkg::MODE_NORMAL)
    else $error("A running channel did not lead to normal mode.");

endmodule // pmc_top

// file: tb/pmc_filter_model.sv
// Behavioural model of the filter side: master clock source and quantiser decisions.
module pmc_filter_model (
  input  wire logic       run,     // Master clock enable.
  input  wire logic [1:0] bits,    // Quantiser decisions to present.
  output logic            mclk,    // Master clock toward the block.
  output logic      [1:0] mod_in   // Quantiser decisions toward the block.
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Master clock, 30 ns period
  // ************************************************************
  // The clock rests low while stopped and after reset, so no rising edge reaches the block.
  initial begin
    mclk = 1'b0;
    #3.7;
    forever begin
      #15;
      if (run) begin
        mclk = ~mclk;
      end else begin
        mclk = 1'b0;
      end
    end
  end

  // The decisions move on the falling edge, away from the block's sampling edge.
  initial mod_in = 2'h0;
  always @(negedge mclk) begin
    mod_in <= bits;
  end
endmodule // pmc_filter_model

// file: tb/tb_pmc_top.sv
// Self-checking testbench of the power-mode and configuration block.
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module tb_pmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 64;
  logic        core_clk, rstn, reg_wr, reg_rd, run, mclk;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  bits, mod_in, mod_out, mod_oe, amp_hiz;
  logic        micro_power;
  int          errors = 0;
  int          total_checks = 0;

  pmc_filter_model pmc_filter_model_i (.run(run), .bits(bits), .mclk(mclk), .mod_in(mod_in));
  pmc_top #(.LOSS_LIMIT(LIMIT)) pmc_top_i (
    .CORE_CLK(core_clk), .RSTN(rstn), .MCLK(mclk), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .MOD_IN(mod_in), .MOD_OUT(mod_out), .MOD_OE(mod_oe), .AMP_HIZ(amp_hiz),
    .MICRO_POWER(micro_power));

  // ************************************************************
  // Clock, bus tasks and helpers
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Write then read with no gap; the read data must stand for one cycle only.
  task automatic wr_rd(input string what, input logic [7:0] a, input logic [31:0] v,
                       input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(what, exp, reg_rdata)
    core(1);
    `CHK("read data released", 32'h0, reg_rdata)
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    `CHK(what, exp, d)
  endtask

  task automatic outs(input string what, input logic [1:0] hiz, input logic mp,
                      input logic [1:0] oe);
    `CHK(what, hiz, amp_hiz)
    `CHK(what, mp, micro_power)
    `CHK(what, oe, mod_oe)
  endtask

  task automatic core(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic mclks(input int n);
    repeat (n) @(posedge mclk);
    core(4);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    outs("reset outputs", 2'h3, 1'b1, 2'h0);
    rd_chk("version", 8'h00, 32'h0000005A);
    rd_chk("power reset", 8'h10, 32'h00000030);
    rd_chk("mod reset", 8'h0C, 32'h00000000);
    rd_chk("status reset", 8'h14, 32'h00000012);
  endtask

  task automatic t_reg_pd();
    run <= 1'b1;
    mclks(10);
    rd_chk("status reg pd", 8'h14, 32'h00000001);
    outs("reg pd outputs", 2'h3, 1'b1, 2'h0);
    wr(8'h04, 32'hFFFFFFA5);
    rd_chk("amp1 in pd", 8'h04, 32'h000000A5);
    wr(8'h00, 32'h00000011);
    wr(8'h14, 32'h000000FF);
    wr(8'h0D, 32'h000000FF);
    rd_chk("version kept", 8'h00, 32'h0000005A);
    rd_chk("misaligned ignored", 8'h0C, 32'h00000000);
    rd_chk("unmapped", 8'h40, 32'h00000000);
  endtask

  // Host sequence: command word then the data byte from the top of the 24-bit data word.
  task automatic t_config();
    logic [23:0] cmd;
    logic [23:0] dat;
    bits <= 2'h2;
    cmd = 24'h000203;
    dat = 24'h400000;
    wr({cmd[5:0], 2'h0}, {24'h0, dat[23:16]});
    core(100);
    cmd = 24'h000204;
    dat = 24'h8F0000;
    wr({cmd[5:0], 2'h0}, {24'h0, dat[23:16]});
    rd_chk("mod cfg", 8'h0C, 32'h00000040);
    rd_chk("power cfg", 8'h10, 32'h0000008F);
    rd_chk("status normal", 8'h14, 32'h0000000C);
    mclks(16);
    outs("normal outputs", 2'h0, 1'b0, 2'h3);
    `CHK("stream bits", 2'h2, mod_out)
  endtask

  task automatic t_stream();
    int n;
    n = 0;
    bits <= 2'h1;
    while (mod_out !== 2'h1 && n < 12) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK("stream latency", 1'b1, n >= 2 && n <= 8)
  endtask

  task automatic t_single();
    bits <= 2'h3;
    wr_rd("power ch0 off", 8'h10, 32'h00000020, 32'h00000020);
    mclks(16);
    outs("ch0 off", 2'h1, 1'b0, 2'h2);
    `CHK("ch0 off stream", 2'h2, mod_out)
    rd_chk("status ch1 only", 8'h14, 32'h00000008);
    wr(8'h10, 32'h00000030);
    outs("both off", 2'h3, 1'b1, 2'h0);
    wr(8'h10, 32'h0000008F);
    mclks(16);
  endtask

  task automatic t_loss();
    run <= 1'b0;
    core(LIMIT - 16);
    rd(8'h14, d);
    `CHK("not yet lost", 1'b0, d[4])
    core(32);
    rd(8'h14, d);
    `CHK("lost mode", 3'h6, {d[4], d[1:0]})
    outs("loss outputs", 2'h3, 1'b1, 2'h0);
    rd_chk("power kept", 8'h10, 32'h0000008F);
    wr(8'h08, 32'h0000003C);
    rd_chk("amp2 in loss", 8'h08, 32'h0000003C);
    run <= 1'b1;
    mclks(16);
    rd_chk("status resumed", 8'h14, 32'h0000000C);
    outs("resumed outputs", 2'h0, 1'b0, 2'h3);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    rd_chk("power cleared", 8'h10, 32'h00000030);
    rd_chk("amp2 cleared", 8'h08, 32'h00000000);
  endtask

  // ************************************************************
  // Main sequence and verdict
  // ************************************************************
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rstn      = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    run       = 1'b0;
    bits      = 2'h0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_reg_pd();
    t_config();
    t_stream();
    t_single();
    t_loss();
    final_report();
  end

  // The whole run needs about 600 core cycles; this bound is many times that.
  initial begin
    #200000;
    errors++;
    final_report();
  end
endmodule // tb_pmc_top
